// ==== hdl/cws_consts.svh ====
// Offsets, field positions, reset values and addresses of the configuration shadow loader
`ifndef CWS_CONSTS_SVH
`define CWS_CONSTS_SVH

// Flash word addresses of the two packed configuration words (top of program memory)
`define CWS_FLASH_HIGH_ADDR   24'h002BFC
`define CWS_FLASH_LOW_ADDR    24'h002BFE

// Configuration space window, reachable by table reads only
`define CWS_CFG_SPACE_BASE    24'h800000
`define CWS_SHADOW_BASE       24'hF80000
`define CWS_SEG_PROT_ADDR     24'hF80004
`define CWS_OSC_SEL_ADDR      24'hF80006
`define CWS_OSC_CFG_ADDR      24'hF80008
`define CWS_WDT_ADDR          24'hF8000A
`define CWS_PWR_PWM_ADDR      24'hF8000C
`define CWS_DEBUG_ADDR        24'hF8000E

// Shadow value before a load: every bit unprogrammed
`define CWS_SHADOW_DEFAULT    8'hFF
`define CWS_UNIMPL_WORD       16'hFFFF
`define CWS_UNIMPL_BYTE       8'hFF

// High configuration word field positions
`define CWS_HI_TWO_SPEED      15
`define CWS_HI_PWM_KEY_LOCK   14
`define CWS_HI_PWM_PIN_RST    13
`define CWS_HI_WDOG_WIN_MSB   12
`define CWS_HI_WDOG_WIN_LSB   11
`define CWS_HI_OSC_SRC_MSB    10
`define CWS_HI_OSC_SRC_LSB    8
`define CWS_HI_CLK_SW_MSB     7
`define CWS_HI_CLK_SW_LSB     6
`define CWS_HI_OSC_PIN_FUNC   5
`define CWS_HI_PIN_MAP_ONCE   4
`define CWS_HI_LOW_SIDE_POL   3
`define CWS_HI_ALT_I2C_PINS   2
`define CWS_HI_PRI_OSC_MSB    1
`define CWS_HI_PRI_OSC_LSB    0

// Low configuration word field positions
`define CWS_LO_RSV_MSB        15
`define CWS_LO_RSV_LSB        14
`define CWS_LO_CODE_PROT      13
`define CWS_LO_WRITE_PROT     12
`define CWS_LO_DEVTOOL        11
`define CWS_LO_HIGH_SIDE_POL  10
`define CWS_LO_DBG_CH_MSB     9
`define CWS_LO_DBG_CH_LSB     8
`define CWS_LO_WDT_MSB        7
`define CWS_LO_WDT_LSB        0

// Shadow field positions
`define CWS_SEG_CODE_PROT_POS  1
`define CWS_SEG_WRITE_PROT_POS 0

`endif

// ==== hdl/cws_loader.sv ====
// Configuration shadow loader: copies two flash words into six read-only shadows on reset
//
// Summary of operation
// RQ1: Shadow bits copy flash bits directly: programmed reads 0, unprogrammed reads 1.
// RQ2: Shadows are read-only, at consecutive addresses in configuration space from 0xF80004.
// RQ3: Configuration space answers table reads only, never fetches or data accesses.
// RQ4: Shadows are volatile and hold no settings until reloaded after power-up.
// RQ5: Loader fetches exactly the two top flash words of program memory.
// RQ6: Every reset, power-on included, starts a fresh transfer into the shadows.
// RQ7: Packed word bits are routed to their own places among six shadows.
// RQ8: Bits 23 to 16 of each flash word are ignored entirely.
// RQ9: Tools program each flash word upper byte as all ones.
// RQ10: Erased (zero) flash words load as zeros, turning code protection on.
// RQ11: Software keeps code off the last page and never erases it.
// RQ12: Unimplemented shadow and flash word bits read as 1.
// RQ13: Debug shadow bits 5 and 4 (low word 15, 14) are programmed 0.
// RQ14: Low word bit 11 is for development tools, programmed 1.
// RQ15: PWM lock, pin reset state and polarity bits exist only on motor variants.
// RQ16: Oscillator pin function bit, high word bit 5, arrives programmed 0.
// RQ17: Code protect at bit 1, write protect at bit 0 of segment shadow.
// RQ18: Code protect 0 protects all user program memory; 1 leaves it open.
// RQ19: Shadows finish loading before core and dependants leave reset.
// RQ20: Before a load completes, shadows show a defined all-ones default.
`timescale 1ns/1ps
`include "cws_consts.svh"

module cws_loader #(
  parameter logic [23:0] FLASH_HIGH_ADDR = `CWS_FLASH_HIGH_ADDR,
  parameter logic [23:0] FLASH_LOW_ADDR  = `CWS_FLASH_LOW_ADDR,
  parameter logic        MC_VARIANT      = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Flash read port
  output logic [23:0]      flash_addr_out,
  output logic             flash_rd_out,
  input  wire logic [23:0] flash_data_in,
  input  wire logic        flash_valid_in,
  // Table read port
  input  wire logic        tbl_rd_in,
  input  wire logic [23:0] tbl_addr_in,
  output logic [15:0]      tbl_data_out,
  output logic             tbl_valid_out,
  output logic             tbl_hit_out,
  // Shadow values
  output logic [7:0]       segment_protect_shadow_out,
  output logic [7:0]       osc_select_shadow_out,
  output logic [7:0]       osc_config_shadow_out,
  output logic [7:0]       watchdog_shadow_out,
  output logic [7:0]       power_pwm_shadow_out,
  output logic [7:0]       debug_channel_shadow_out,
  // Decoded controls
  output logic             code_protect_out,
  output logic             write_protect_out,
  output logic             core_rst_out,
  output logic             load_done_out
);

  cws_pkg::cws_state_t load_state;
  cws_pkg::cws_state_t next_load_state;
  logic [15:0]         high_word;

  // Only the low 16 bits carry configuration; the upper byte is never looked at
  wire [15:0] hi = high_word;                       // [RQ8]
  wire [15:0] lo = flash_data_in[15:0];             // [RQ8]

  // Motor-control bits read 1 on other variants
  wire pwm_key_lock_bit        = MC_VARIANT ? hi[`CWS_HI_PWM_KEY_LOCK]  : 1'b1; // [RQ15]
  wire pwm_pin_reset_state_bit = MC_VARIANT ? hi[`CWS_HI_PWM_PIN_RST]   : 1'b1; // [RQ15]
  wire low_side_polarity_bit   = MC_VARIANT ? hi[`CWS_HI_LOW_SIDE_POL]  : 1'b1; // [RQ15]
  wire high_side_polarity_bit  = MC_VARIANT ? lo[`CWS_LO_HIGH_SIDE_POL] : 1'b1; // [RQ15]

  // Unpacking; bits are copied as stored so programmed bits stay 0 and erased words give 0
  wire [7:0] next_seg  = {6'h3F, lo[`CWS_LO_CODE_PROT],
                          lo[`CWS_LO_WRITE_PROT]};                      // [RQ7] [RQ17] [RQ12]
  wire [7:0] next_osel = {hi[`CWS_HI_TWO_SPEED], pwm_key_lock_bit, 1'b1,
                          hi[`CWS_HI_WDOG_WIN_MSB:`CWS_HI_WDOG_WIN_LSB],
                          hi[`CWS_HI_OSC_SRC_MSB:`CWS_HI_OSC_SRC_LSB]}; // [RQ7]
  wire [7:0] next_ocfg = {hi[`CWS_HI_CLK_SW_MSB:`CWS_HI_CLK_SW_LSB],
                          hi[`CWS_HI_PIN_MAP_ONCE], 2'h3, hi[`CWS_HI_OSC_PIN_FUNC],
                          hi[`CWS_HI_PRI_OSC_MSB:`CWS_HI_PRI_OSC_LSB]}; // [RQ7] [RQ16]
  wire [7:0] next_wdt  = lo[`CWS_LO_WDT_MSB:`CWS_LO_WDT_LSB];           // [RQ1] [RQ7]
  wire [7:0] next_pwr  = {pwm_pin_reset_state_bit, high_side_polarity_bit,
                          low_side_polarity_bit, hi[`CWS_HI_ALT_I2C_PINS],
                          4'hF};                                        // [RQ7] [RQ12]
  wire [7:0] next_dbg  = {lo[`CWS_LO_DEVTOOL], 1'b1, lo[`CWS_LO_RSV_MSB:`CWS_LO_RSV_LSB],
                          2'h3, lo[`CWS_LO_DBG_CH_MSB:`CWS_LO_DBG_CH_LSB]}; // [RQ7] [RQ13] [RQ14]

  wire take_high = (load_state == cws_pkg::CWS_REQ_HI) && flash_valid_in;
  wire take_low  = (load_state == cws_pkg::CWS_REQ_LO) && flash_valid_in;

  // Load sequencer: high word, then low word, then idle until the next reset
  always_comb
  begin
    next_load_state = load_state;
    unique case (load_state)
      cws_pkg::CWS_REQ_HI:
      begin
        if (flash_valid_in)
          next_load_state = cws_pkg::CWS_REQ_LO;
      end
      cws_pkg::CWS_REQ_LO:
      begin
        if (flash_valid_in)
          next_load_state = cws_pkg::CWS_DONE;
      end
      cws_pkg::CWS_DONE:
        next_load_state = cws_pkg::CWS_DONE;
      default:
        next_load_state = cws_pkg::CWS_REQ_HI;
    endcase
  end

  wire [23:0] next_flash_addr = (next_load_state == cws_pkg::CWS_REQ_LO) ?
                                FLASH_LOW_ADDR : FLASH_HIGH_ADDR;         // [RQ5]
  wire        next_flash_rd   = (next_load_state != cws_pkg::CWS_DONE);

  // Any reset restarts the sequence from the high word
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      load_state     <= cws_pkg::CWS_REQ_HI;       // [RQ6]
      flash_addr_out <= FLASH_HIGH_ADDR;           // [RQ5]
      flash_rd_out   <= 1'b0;
      high_word      <= `CWS_UNIMPL_WORD;
      load_done_out  <= 1'b0;
    end
    else
    begin
      load_state     <= next_load_state;
      flash_addr_out <= next_flash_addr;
      flash_rd_out   <= next_flash_rd;
      load_done_out  <= (next_load_state == cws_pkg::CWS_DONE);
      if (take_high)
        high_word <= flash_data_in[15:0];
    end
  end

  // Core stays in reset until the shadows are valid, so nobody sees stale settings
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      core_rst_out <= 1'b1;                        // [RQ19]
    else
      core_rst_out <= (next_load_state != cws_pkg::CWS_DONE); // [RQ19]
  end

  // Volatile shadows: forced to the unprogrammed default on every reset
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      segment_protect_shadow_out <= `CWS_SHADOW_DEFAULT; // [RQ4] [RQ20]
      osc_select_shadow_out      <= `CWS_SHADOW_DEFAULT;
      osc_config_shadow_out      <= `CWS_SHADOW_DEFAULT;
      watchdog_shadow_out        <= `CWS_SHADOW_DEFAULT;
      power_pwm_shadow_out       <= `CWS_SHADOW_DEFAULT;
      debug_channel_shadow_out   <= `CWS_SHADOW_DEFAULT;
      code_protect_out           <= 1'b0;
      write_protect_out          <= 1'b0;
    end
    else if (take_low)
    begin
      // Both words land together, so no shadow ever mixes an old and a new word
      segment_protect_shadow_out <= next_seg;
      osc_select_shadow_out      <= next_osel;
      osc_config_shadow_out      <= next_ocfg;
      watchdog_shadow_out        <= next_wdt;
      power_pwm_shadow_out       <= next_pwr;
      debug_channel_shadow_out   <= next_dbg;
      code_protect_out           <= ~next_seg[`CWS_SEG_CODE_PROT_POS];  // [RQ18] [RQ10]
      write_protect_out          <= ~next_seg[`CWS_SEG_WRITE_PROT_POS]; // [RQ17]
    end
  end

  // Table read decode; there is no write path, so the shadows are read-only
  wire in_cfg_space = (tbl_addr_in >= `CWS_CFG_SPACE_BASE);      // [RQ3]
  wire hit_seg  = (tbl_addr_in == `CWS_SEG_PROT_ADDR);           // [RQ2]
  wire hit_osel = (tbl_addr_in == `CWS_OSC_SEL_ADDR);
  wire hit_ocfg = (tbl_addr_in == `CWS_OSC_CFG_ADDR);
  wire hit_wdt  = (tbl_addr_in == `CWS_WDT_ADDR);
  wire hit_pwr  = (tbl_addr_in == `CWS_PWR_PWM_ADDR);
  wire hit_dbg  = (tbl_addr_in == `CWS_DEBUG_ADDR);

  wire [7:0] sel_byte = hit_seg  ? segment_protect_shadow_out :
                        hit_osel ? osc_select_shadow_out :
                        hit_ocfg ? osc_config_shadow_out :
                        hit_wdt  ? watchdog_shadow_out :
                        hit_pwr  ? power_pwm_shadow_out :
                        hit_dbg  ? debug_channel_shadow_out :
                        `CWS_UNIMPL_BYTE;

  // Upper byte of each shadow word is unimplemented and reads as ones
  wire [15:0] next_tbl_data = {`CWS_UNIMPL_BYTE, sel_byte};      // [RQ12]

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      tbl_valid_out <= 1'b0;
      tbl_hit_out   <= 1'b0;
      tbl_data_out  <= `CWS_UNIMPL_WORD;
    end
    else
    begin
      tbl_valid_out <= tbl_rd_in;                                // [RQ3]
      tbl_hit_out   <= tbl_rd_in && in_cfg_space;                // [RQ3]
      tbl_data_out  <= (tbl_rd_in && in_cfg_space) ? next_tbl_data : `CWS_UNIMPL_WORD;
    end
  end

  // Checks
  a_core_held_load: // [RQ19]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (load_state != cws_pkg::CWS_DONE) |-> core_rst_out)
      else $error("core released before shadows loaded");

  a_high_word_fetch: // [RQ5]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (flash_rd_out && load_state == cws_pkg::CWS_REQ_HI) |-> flash_addr_out == FLASH_HIGH_ADDR)
      else $error("high word fetched from wrong address");

  a_low_word_fetch: // [RQ5]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (flash_rd_out && load_state == cws_pkg::CWS_REQ_LO) |-> flash_addr_out == FLASH_LOW_ADDR)
      else $error("low word fetched from wrong address");

  a_unpack_copy: // [RQ7]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      take_low |=> (watchdog_shadow_out == $past(flash_data_in[7:0])) &&
                   (debug_channel_shadow_out[1:0] == $past(flash_data_in[9:8])) &&
                   (segment_protect_shadow_out[1:0] == $past(flash_data_in[13:12])))
      else $error("shadow does not match packed word");

  a_code_protect_map: // [RQ18]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (load_state == cws_pkg::CWS_DONE) |->
        code_protect_out == !segment_protect_shadow_out[1])
      else $error("code protect does not follow shadow bit");

  a_unimpl_ones: // [RQ12]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (segment_protect_shadow_out[7:2] == 6'h3F) && (power_pwm_shadow_out[3:0] == 4'hF))
      else $error("unimplemented shadow bit reads zero");

  a_variant_pwm: // [RQ15]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (MC_VARIANT == 1'b0) |-> (power_pwm_shadow_out[7:5] == 3'h7) && osc_select_shadow_out[6])
      else $error("pwm bit present on non motor variant");

  a_table_answer: // [RQ2]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (tbl_rd_in && tbl_addr_in == `CWS_SEG_PROT_ADDR && !take_low) |=>
        tbl_valid_out && tbl_data_out == {8'hFF, segment_protect_shadow_out})
      else $error("segment shadow table read wrong");

  a_table_only: // [RQ3]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (!tbl_rd_in || tbl_addr_in < `CWS_CFG_SPACE_BASE) |=> !tbl_hit_out)
      else $error("configuration space reached without table read");

  a_reset_reload: // [RQ6]
    assert property (@(posedge mclk_in)
      rst_in |=> (load_state == cws_pkg::CWS_REQ_HI) && core_rst_out &&
                 (segment_protect_shadow_out == 8'hFF))
      else $error("reset did not restart the load");

  a_shadow_read_only: // [RQ2]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !take_low |=> $stable({segment_protect_shadow_out, osc_select_shadow_out,
                             osc_config_shadow_out, watchdog_shadow_out,
                             power_pwm_shadow_out, debug_channel_shadow_out}))
      else $error("shadow changed outside a load");

  a_done_holds: // [RQ5]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (load_state == cws_pkg::CWS_DONE) |=>
        (load_state == cws_pkg::CWS_DONE) && !flash_rd_out)
      else $error("flash read after the load finished");

  a_default_before_load: // [RQ20] [RQ4]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      (load_state != cws_pkg::CWS_DONE) |->
        (segment_protect_shadow_out == `CWS_SHADOW_DEFAULT) &&
        (debug_channel_shadow_out == `CWS_SHADOW_DEFAULT))
      else $error("shadow left default before the load completed");

  a_protect_before_load: // [RQ20]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !load_done_out |-> !code_protect_out && !write_protect_out)
      else $error("protection active before the load completed");

  a_table_pulse: // [RQ3]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      tbl_rd_in |=> tbl_valid_out)
      else $error("table read not answered");

  a_table_idle: // [RQ12]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !tbl_rd_in |=> !tbl_valid_out && (tbl_data_out == `CWS_UNIMPL_WORD))
      else $error("table port active without a read");

  a_upper_byte_ones: // [RQ12]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      tbl_valid_out |-> (tbl_data_out[15:8] == `CWS_UNIMPL_BYTE))
      else $error("upper byte of table data not all ones");

  a_high_capture: // [RQ8]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      take_high |=> (high_word == $past(flash_data_in[15:0])))
      else $error("high word not captured from its low 16 bits");

  a_erased_protects: // [RQ10]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      take_low && !flash_data_in[`CWS_LO_CODE_PROT] |=> code_protect_out)
      else $error("erased code protect bit did not enable protection");

  a_write_protect_map: // [RQ17]
    assert property (@(posedge mclk_in) disable iff (rst_in)
      load_done_out |->
        (write_protect_out == !segment_protect_shadow_out[`CWS_SEG_WRITE_PROT_POS]))
      else $error("write protect does not follow shadow bit");

endmodule

// ==== hdl/cws_pkg.sv ====
// Types shared by the configuration shadow loader
package cws_pkg;
  typedef enum logic [1:0] {
    CWS_REQ_HI = 2'h0,
    CWS_REQ_LO = 2'h1,
    CWS_DONE   = 2'h3
  } cws_state_t;
endpackage

// ==== verification/cws_flash_model.sv ====
// Flash program memory model answering the loader's word reads
`timescale 1ns/1ps

module cws_flash_model (
  // Clock
  input  wire logic        mclk_in,
  // Read port
  input  wire logic [23:0] flash_addr_in,
  input  wire logic        flash_rd_in,
  output logic [23:0]      flash_data_out,
  output logic             flash_valid_out,
  // Contents and pacing
  input  wire logic [23:0] word_high_in,
  input  wire logic [23:0] word_low_in,
  input  wire logic [3:0]  delay_in
);
  logic [3:0] wait_cnt = 4'h0;
  wire        is_high = flash_addr_in === 24'h002BFC;
  wire        is_low  = flash_addr_in === 24'h002BFE;
  wire        answer  = flash_rd_in && !flash_valid_out && wait_cnt >= delay_in;

  initial
  begin
    flash_data_out  = 24'hA5A5A5;
    flash_valid_out = 1'b0;
  end

  // Only the two top words hold configuration; any other address returns junk
  always @(posedge mclk_in)
  begin
    if (answer)
    begin
      flash_valid_out <= 1'b1;
      flash_data_out  <= is_high ? word_high_in : (is_low ? word_low_in : ~flash_data_out);
      wait_cnt        <= 4'h0;
    end
    else
    begin
      // A released bus must not keep showing the last word
      flash_valid_out <= 1'b0;
      flash_data_out  <= ~flash_data_out;
      wait_cnt        <= (flash_rd_in && !flash_valid_out) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== verification/cws_loader_tb_top.sv ====
// Self-checking bench for the configuration shadow loader
`timescale 1ns/1ps

module cws_loader_tb_top;
  logic        mclk_in     = 1'b0;
  logic        rst_in      = 1'b1;
  logic        tbl_rd_in   = 1'b0;
  logic [23:0] tbl_addr_in = 24'h000000;
  logic [23:0] word_high   = 24'hFFFFFF;
  logic [23:0] word_low    = 24'hFFFFFF;
  logic [3:0]  delay       = 4'h0;
  logic [23:0] flash_addr;
  logic [23:0] flash_data;
  logic        flash_rd;
  logic        flash_valid;
  logic [15:0] tbl_data;
  logic        tbl_valid;
  logic        tbl_hit;
  logic [7:0]  shadow [6];
  logic [7:0]  gp_shadow [6];
  logic        code_protect;
  logic        write_protect;
  logic        core_rst;
  logic        load_done;
  int          n_fail      = 0;
  int          checked     = 0;
  logic [23:0] bad [7]     = '{24'hF80000, 24'hF80002, 24'hF80005, 24'hF80010,
                               24'hFFFFFE, 24'h002BFC, 24'h7FFFFE};

  always #2.5 mclk_in = ~mclk_in;

  cws_loader cws_loader_i (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .flash_addr_out(flash_addr), .flash_rd_out(flash_rd),
    .flash_data_in(flash_data), .flash_valid_in(flash_valid),
    .tbl_rd_in(tbl_rd_in), .tbl_addr_in(tbl_addr_in), .tbl_data_out(tbl_data),
    .tbl_valid_out(tbl_valid), .tbl_hit_out(tbl_hit),
    .segment_protect_shadow_out(shadow[0]), .osc_select_shadow_out(shadow[1]),
    .osc_config_shadow_out(shadow[2]), .watchdog_shadow_out(shadow[3]),
    .power_pwm_shadow_out(shadow[4]), .debug_channel_shadow_out(shadow[5]),
    .code_protect_out(code_protect), .write_protect_out(write_protect),
    .core_rst_out(core_rst), .load_done_out(load_done));

  // Second loader built as the variant without motor-control bits
  cws_loader #(.MC_VARIANT(1'b0)) cws_loader_gp_i (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .flash_addr_out(), .flash_rd_out(),
    .flash_data_in(flash_data), .flash_valid_in(flash_valid),
    .tbl_rd_in(tbl_rd_in), .tbl_addr_in(tbl_addr_in), .tbl_data_out(),
    .tbl_valid_out(), .tbl_hit_out(),
    .segment_protect_shadow_out(gp_shadow[0]), .osc_select_shadow_out(gp_shadow[1]),
    .osc_config_shadow_out(gp_shadow[2]), .watchdog_shadow_out(gp_shadow[3]),
    .power_pwm_shadow_out(gp_shadow[4]), .debug_channel_shadow_out(gp_shadow[5]),
    .code_protect_out(), .write_protect_out(),
    .core_rst_out(), .load_done_out());

  cws_flash_model cws_flash_model_i (
    .mclk_in(mclk_in), .flash_addr_in(flash_addr), .flash_rd_in(flash_rd),
    .flash_data_out(flash_data), .flash_valid_out(flash_valid),
    .word_high_in(word_high), .word_low_in(word_low), .delay_in(delay));

  function automatic logic [7:0] exp_shadow(input int idx, input logic [23:0] hi, lo);
    case (idx)
      0: return {6'h3F, lo[13], lo[12]};
      1: return {hi[15], hi[14], 1'b1, hi[12:8]};
      2: return {hi[7:6], hi[4], 2'b11, hi[5], hi[1:0]};
      3: return lo[7:0];
      4: return {hi[13], lo[10], hi[3], hi[2], 4'hF};
      default: return {lo[11], 1'b1, lo[15:14], 2'b11, lo[9:8]};
    endcase
  endfunction

  // Motor-control bits are forced to 1 on the other variant
  function automatic logic [7:0] gp_mask(input int idx);
    return (idx == 1) ? 8'h40 : ((idx == 4) ? 8'hE0 : 8'h00);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Leaves the strobe high so calls in a row run back to back
  task automatic tread(input logic [23:0] a, input logic [15:0] exp, input logic hit);
    tbl_rd_in   = 1'b1;
    tbl_addr_in = a;
    @(negedge mclk_in);
    chk({15'h0, tbl_valid}, 16'h0001);
    chk({15'h0, tbl_hit}, {15'h0, hit});
    chk(tbl_data, exp);
  endtask

  task automatic load(input logic [23:0] hi, input logic [23:0] lo, input logic [3:0] d);
    int i;
    word_high = hi;
    word_low  = lo;
    delay     = d;
    rst_in    = 1'b1;
    repeat (6) @(negedge mclk_in);
    chk({14'h0, core_rst, load_done}, 16'h0002);
    chk({8'h0, shadow[0]}, 16'h00FF);
    rst_in = 1'b0;
    @(negedge mclk_in);
    tread(24'hF80004, 16'hFFFF, 1'b1);
    tbl_rd_in = 1'b0;
    chk({15'h0, core_rst}, 16'h0001);
    i = 0;
    while (load_done !== 1'b1 && i < 40)
    begin
      @(negedge mclk_in);
      i++;
    end
    chk({14'h0, core_rst, load_done}, 16'h0001);
    chk({14'h0, code_protect, write_protect}, {14'h0, ~lo[13], ~lo[12]});
    for (i = 0; i < 6; i++)
    begin
      chk({8'h0, shadow[i]}, {8'h0, exp_shadow(i, hi, lo)});
      chk({8'h0, gp_shadow[i]}, {8'h0, exp_shadow(i, hi, lo) | gp_mask(i)});
      tread(24'hF80004 + 24'(2 * i), {8'hFF, exp_shadow(i, hi, lo)}, 1'b1);
    end
    tbl_rd_in = 1'b0;
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hAD58));
    load(24'hFFFFDF, 24'hFF3FFF, 4'h0);
    load(24'h000000, 24'h000000, 4'h3);
    // Let an edge pass so the strobe is not lowered and raised in one step
    @(negedge mclk_in);
    foreach (bad[k]) tread(bad[k], 16'hFFFF, bad[k] >= 24'h800000);
    tbl_rd_in = 1'b0;
    // Random upper bytes show that bits 23 to 16 carry nothing
    repeat (8) load(24'($urandom), 24'($urandom), 4'($urandom % 6));
    close_out();
  end

  // All loads finish in a few hundred cycles; this margin only catches a hang
  initial
  begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
